// >>> design/pir_consts.svh
// Timing and filter constants of the motion detect logic
`ifndef PIR_CONSTS_SVH
`define PIR_CONSTS_SVH

// Fast system clock and nominal slow oscillator (62.5 Hz)
`define PIR_SYS_PERIOD_NS     20
`define PIR_OSC_PERIOD_US     16000
`define PIR_OSC_DIV           ((`PIR_OSC_PERIOD_US * 1000) / `PIR_SYS_PERIOD_NS)

// Start-up phase, 30 s, exact in ticks
`define PIR_STARTUP_MS        30000
`define PIR_STARTUP_TICKS     ((`PIR_STARTUP_MS * 1000) / `PIR_OSC_PERIOD_US)

// Start-up blink at 2 Hz: half period 250 ms, rounded up
`define PIR_BLINK_HALF_MS     250
`define PIR_BLINK_TICKS       ((`PIR_BLINK_HALF_MS * 1000 + `PIR_OSC_PERIOD_US - 1) / `PIR_OSC_PERIOD_US)

// Dual pulse window, 5 s, rounded down
`define PIR_TIMEOUT_MS        5000
`define PIR_TIMEOUT_TICKS     ((`PIR_TIMEOUT_MS * 1000) / `PIR_OSC_PERIOD_US)

// Consecutive high samples for a valid pulse
`define PIR_DEGLITCH_SAMPLES  3

// Detection hold time in ticks (2 s)
`define PIR_HOLD_TICKS        125

`endif

// >>> design/pir_pkg.sv
// Types shared by the motion detect logic
`default_nettype none

package pir_pkg;

    typedef enum logic [1:0] {
        ST_STARTUP,
        ST_IDLE,
        ST_WAIT2,
        ST_HOLD
    } pir_phase_e;

    typedef struct packed {
        logic upper;
        logic lower;
    } pir_comp_s;

    typedef struct packed {
        logic dualMode;
        logic indicatorEnableN;
    } pir_ctl_s;

endpackage : pir_pkg

`default_nettype wire

// >>> design/pir_deglitch.sv
// Comparator pulse deglitch filter counting slow oscillator samples
`default_nettype none

module pir_deglitch #(
    parameter int SAMPLES = 3
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic ce,
    // Sampling
    input  wire logic tick,
    input  wire logic level,
    // Result
    output logic      qualPulse
);

    localparam int CW = $clog2(SAMPLES + 1);

    logic [CW-1:0] run_reg;
    logic [CW-1:0] run_next;
    logic          qual_reg;
    logic          qual_next;

    // Saturating run of high samples; one pulse per accepted comparator pulse
    always_comb
    begin
        run_next  = run_reg;
        qual_next = 1'b0;
        if (tick)
        begin
            if (!level)
                run_next = '0;
            else if (run_reg != CW'(SAMPLES))
                run_next = run_reg + CW'(1);
            qual_next = level && (run_reg == CW'(SAMPLES - 1));
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            run_reg  <= '0;
            qual_reg <= 1'b0;
        end
        else if (ce)
        begin
            run_reg  <= run_next;
            qual_reg <= qual_next;
        end
    end

    assign qualPulse = qual_reg;

    a_reject_short: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(qual_reg) |-> $past(run_reg) == CW'(SAMPLES - 1) && $past(level))
        else $error("pulse accepted before enough samples");

    a_accept_long: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ce && tick && level && run_reg == CW'(SAMPLES - 1)) |=> qual_reg ##1 !qual_reg || !ce)
        else $error("long pulse not accepted");

endmodule : pir_deglitch

`default_nettype wire

// >>> design/pir_detect.sv
// Motion detect logic: start-up, deglitch, pulse recognition, outputs
// Overview of operation
// - Every duration is a count of slow oscillator ticks, nominally 62.5 Hz.
// - Comparators are sampled on oscillator ticks; detect and indicator rise two system clocks after the accepting tick.
// - During start-up the indicator toggles at about 2 Hz whatever the enable pin says.
// - Start-up lasts thirty seconds, then motion detection begins.
// - Detect output stays low for all of start-up.
// - A comparator pulse shorter than two periods is never accepted.
// - A comparator pulse longer than three periods is always accepted.
// - With mode low one accepted pulse from either comparator gives a detection.
// - With mode high a detection needs pulses from both comparators within five seconds.
// - In dual mode an expired window discards the first pulse and restarts recognition.
// - With the enable pin high the indicator stays off on detection.
// - With the enable pin low the indicator turns on with each detection.
// - The two comparator inputs mean upper threshold exceeded and lower threshold undershot.
`default_nettype none
`include "pir_consts.svh"

module pir_detect #(
    parameter int OSC_DIV       = `PIR_OSC_DIV,
    parameter int STARTUP_TICKS = `PIR_STARTUP_TICKS,
    parameter int BLINK_TICKS   = `PIR_BLINK_TICKS,
    parameter int TIMEOUT_TICKS = `PIR_TIMEOUT_TICKS,
    parameter int HOLD_TICKS    = `PIR_HOLD_TICKS,
    parameter int SAMPLES       = `PIR_DEGLITCH_SAMPLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // Window comparator pins
    input  wire pir_pkg::pir_comp_s compRaw,
    // Strap pins
    input  wire logic        dualModeSel,
    input  wire logic        indicatorEnableN,
    // Outputs
    output logic             detectOut,
    output logic             indicatorOut
);

    import pir_pkg::*;

    localparam int DW = $clog2(OSC_DIV);
    localparam int TW = 16;
    localparam int BW = $clog2(BLINK_TICKS + 1);

    // Input synchronisers
    pir_comp_s compMeta_reg;
    pir_comp_s compSync_reg;
    pir_ctl_s  ctlMeta_reg;
    pir_ctl_s  ctlSync_reg;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            compMeta_reg <= '0;
            compSync_reg <= '0;
            ctlMeta_reg  <= '{dualMode: 1'b0, indicatorEnableN: 1'b1};
            ctlSync_reg  <= '{dualMode: 1'b0, indicatorEnableN: 1'b1};
        end
        else if (ce)
        begin
            compMeta_reg <= compRaw;
            compSync_reg <= compMeta_reg;
            ctlMeta_reg  <= '{dualMode: dualModeSel, indicatorEnableN: indicatorEnableN};
            ctlSync_reg  <= ctlMeta_reg;
        end
    end

    // Slow oscillator tick from the fast clock
    logic [DW-1:0] div_reg;
    logic [DW-1:0] div_next;
    logic          tickEn;

    always_comb
    begin
        tickEn   = (div_reg == DW'(OSC_DIV - 1));
        div_next = tickEn ? '0 : div_reg + DW'(1);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            div_reg <= '0;
        else if (ce)
            div_reg <= div_next;
    end

    // Deglitch, sampled on ticks only
    wire pir_comp_s qual;

    pir_deglitch #(.SAMPLES(SAMPLES)) u_deglitch_upper (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .tick      (tickEn),
        .level     (compSync_reg.upper),
        .qualPulse (qual.upper)
    );

    pir_deglitch #(.SAMPLES(SAMPLES)) u_deglitch_lower (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .tick      (tickEn),
        .level     (compSync_reg.lower),
        .qualPulse (qual.lower)
    );

    // Recognition and output state
    pir_phase_e    phase_reg;
    pir_phase_e    phase_next;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] timer_next;
    logic [BW-1:0] blink_reg;
    logic [BW-1:0] blink_next;
    logic          firstUpper_reg;
    logic          firstUpper_next;
    logic          detectOut_reg;
    logic          detectOut_next;
    logic          indicatorOut_reg;
    logic          indicatorOut_next;
    logic          opposite;
    logic          same;

    always_comb
    begin
        phase_next        = phase_reg;
        timer_next        = timer_reg;
        blink_next        = blink_reg;
        firstUpper_next   = firstUpper_reg;
        detectOut_next    = detectOut_reg;
        indicatorOut_next = indicatorOut_reg;
        opposite = firstUpper_reg ? qual.lower : qual.upper;
        same     = firstUpper_reg ? qual.upper : qual.lower;
        case (phase_reg)
            ST_STARTUP:
            begin
                detectOut_next = 1'b0;
                if (tickEn)
                begin
                    // Blink ignores the enable strap
                    if (blink_reg == BW'(BLINK_TICKS - 1))
                    begin
                        blink_next        = '0;
                        indicatorOut_next = !indicatorOut_reg;
                    end
                    else
                        blink_next = blink_reg + BW'(1);
                    if (timer_reg == TW'(STARTUP_TICKS - 1))
                    begin
                        phase_next        = ST_IDLE;
                        timer_next        = '0;
                        indicatorOut_next = 1'b0;
                    end
                    else
                        timer_next = timer_reg + TW'(1);
                end
            end
            ST_IDLE:
            begin
                detectOut_next    = 1'b0;
                indicatorOut_next = 1'b0;
                timer_next        = '0;
                if (qual.upper || qual.lower)
                begin
                    if (!ctlSync_reg.dualMode)
                    begin
                        phase_next        = ST_HOLD;
                        detectOut_next    = 1'b1;
                        indicatorOut_next = !ctlSync_reg.indicatorEnableN;
                    end
                    else
                    begin
                        phase_next      = ST_WAIT2;
                        firstUpper_next = qual.upper;
                    end
                end
            end
            ST_WAIT2:
            begin
                if (opposite)
                begin
                    phase_next        = ST_HOLD;
                    timer_next        = '0;
                    detectOut_next    = 1'b1;
                    indicatorOut_next = !ctlSync_reg.indicatorEnableN;
                end
                else if (same)
                    timer_next = '0;
                else if (tickEn)
                begin
                    // Late second pulse finds the idle state and starts over
                    if (timer_reg == TW'(TIMEOUT_TICKS - 1))
                        phase_next = ST_IDLE;
                    else
                        timer_next = timer_reg + TW'(1);
                end
            end
            ST_HOLD:
            begin
                if (tickEn)
                begin
                    if (timer_reg == TW'(HOLD_TICKS - 1))
                    begin
                        phase_next        = ST_IDLE;
                        timer_next        = '0;
                        detectOut_next    = 1'b0;
                        indicatorOut_next = 1'b0;
                    end
                    else
                        timer_next = timer_reg + TW'(1);
                end
            end
            default:
            begin
                phase_next = ST_STARTUP;
                timer_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase_reg        <= ST_STARTUP;
            timer_reg        <= '0;
            blink_reg        <= '0;
            firstUpper_reg   <= 1'b0;
            detectOut_reg    <= 1'b0;
            indicatorOut_reg <= 1'b0;
        end
        else if (ce)
        begin
            phase_reg        <= phase_next;
            timer_reg        <= timer_next;
            blink_reg        <= blink_next;
            firstUpper_reg   <= firstUpper_next;
            detectOut_reg    <= detectOut_next;
            indicatorOut_reg <= indicatorOut_next;
        end
    end

    assign detectOut    = detectOut_reg;
    assign indicatorOut = indicatorOut_reg;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_detect_start;
        $rose(detectOut_reg);
    endsequence

    a_startup_quiet: assert property (
        phase_reg == ST_STARTUP |-> !detectOut_reg)
        else $error("detect high during start-up");

    a_startup_length: assert property (
        $fell(phase_reg == ST_STARTUP) |-> $past(timer_reg) == TW'(STARTUP_TICKS - 1) && phase_reg == ST_IDLE)
        else $error("start-up ended at wrong count");

    a_blink_rate: assert property (
        (phase_reg == ST_STARTUP && $changed(indicatorOut_reg))
            |-> $past(blink_reg) == BW'(BLINK_TICKS - 1) && $past(tickEn))
        else $error("start-up blink off rate");

    a_single_detect: assert property (
        (ce && phase_reg == ST_IDLE && !ctlSync_reg.dualMode && (qual.upper || qual.lower))
            |=> detectOut_reg && phase_reg == ST_HOLD)
        else $error("single pulse not detected");

    a_dual_needs_pair: assert property (
        (s_detect_start and $past(ctlSync_reg.dualMode)) |-> $past(phase_reg) == ST_WAIT2)
        else $error("dual mode detected without two pulses");

    a_window_bound: assert property (
        phase_reg == ST_WAIT2 |-> timer_reg < TW'(TIMEOUT_TICKS))
        else $error("dual window overran");

    a_indicator_gate: assert property (
        s_detect_start |-> indicatorOut_reg == !$past(ctlSync_reg.indicatorEnableN))
        else $error("indicator does not follow enable");

    a_hold_length: assert property (
        $fell(detectOut_reg) |-> $past(timer_reg) == TW'(HOLD_TICKS - 1) && phase_reg == ST_IDLE)
        else $error("detect hold length wrong");

endmodule : pir_detect

`default_nettype wire

// >>> tb/pir_comp_src.sv
// Comparator and strap pin source for the motion detect bench
`default_nettype none

module pir_comp_src #(
    parameter int OSC_DIV = 4
) (
    // Clock
    input  wire logic          clk_sys,
    // Pins toward the block
    output var pir_pkg::pir_comp_s compRaw,
    output logic               dualModeSel,
    output logic               indicatorEnableN
);
    timeunit 1ns;
    timeprecision 1ps;
    import pir_pkg::*;

    initial
    begin
        compRaw = '0;
        dualModeSel = 1'b0;
        indicatorEnableN = 1'b1;
    end

    // Straps are static on a board, so changes only between scenarios
    task automatic set_straps(input logic dual, input logic enN);
        @(posedge clk_sys);
        dualModeSel <= dual;
        indicatorEnableN <= enN;
        repeat (4) @(posedge clk_sys);
    endtask : set_straps

    // Upper: amplifier above upper_threshold; lower: below lower_threshold
    task automatic pulse(input logic isUpper, input int ticks);
        @(posedge clk_sys);
        if (isUpper)
            compRaw.upper <= 1'b1;
        else
            compRaw.lower <= 1'b1;
        repeat (ticks * OSC_DIV) @(posedge clk_sys);
        compRaw <= '0;
    endtask : pulse
endmodule : pir_comp_src

`default_nettype wire

// >>> tb/tb_pir_detect.sv
// Self-checking bench of the motion detect logic
`default_nettype none

module tb_pir_detect;
    timeunit 1ns;
    timeprecision 1ps;
    import pir_pkg::*;

    localparam int DIV   = 4;
    localparam int START = 20;
    localparam int BLINK = 2;
    // Window must outlast the gap between two back-to-back try_pulse calls
    localparam int TOUT  = 16;
    localparam int HOLD  = 5;
    localparam int LIMIT = 20000;

    logic      clk_sys;
    logic      sys_rst;
    logic      ce;
    pir_comp_s compRaw;
    logic      dualModeSel;
    logic      indicatorEnableN;
    logic      detectOut;
    logic      indicatorOut;
    int        error_cnt;
    int        comparisons;
    int        cyc;
    int        len;
    logic      side;
    logic      enN;

    pir_detect #(
        .OSC_DIV       (DIV),
        .STARTUP_TICKS (START),
        .BLINK_TICKS   (BLINK),
        .TIMEOUT_TICKS (TOUT),
        .HOLD_TICKS    (HOLD),
        .SAMPLES       (3)
    ) u_dut (
        .clk_sys          (clk_sys),
        .sys_rst          (sys_rst),
        .ce               (ce),
        .compRaw          (compRaw),
        .dualModeSel      (dualModeSel),
        .indicatorEnableN (indicatorEnableN),
        .detectOut        (detectOut),
        .indicatorOut     (indicatorOut)
    );

    pir_comp_src #(
        .OSC_DIV (DIV)
    ) u_src (
        .clk_sys          (clk_sys),
        .compRaw          (compRaw),
        .dualModeSel      (dualModeSel),
        .indicatorEnableN (indicatorEnableN)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (4) @(negedge clk_sys);
        check(detectOut, 1'b0);
        check(indicatorOut, 1'b0);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask : do_reset

    // Toggle times go in a queue; a comparator is busy for the first ten ticks
    task automatic run_startup();
        int   q[$];
        int   n;
        logic lastInd;
        lastInd = 1'b0;
        fork
            u_src.pulse(1'b1, 10);
        join_none
        for (n = 0; n < START * DIV + 8; n++)
        begin
            @(negedge clk_sys);
            check(detectOut, 1'b0);
            if (indicatorOut !== lastInd)
                q.push_back(n);
            lastInd = indicatorOut;
        end
        for (n = 1; n < q.size(); n++)
            check(q[n] - q[n - 1] == BLINK * DIV, 1'b1);
        check(q.size() >= START / BLINK - 1 && q.size() <= START / BLINK, 1'b1);
        check(indicatorOut, 1'b0);
    endtask : run_startup

    // Pulse source runs beside the watch so that early rises are seen
    task automatic try_pulse(input logic up, input int ticks, input logic want, input logic en);
        int n;
        int hi;
        n = 0;
        hi = 0;
        fork
            u_src.pulse(up, ticks);
        join_none
        while (n < (ticks + 4) * DIV && detectOut !== 1'b1)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(detectOut, want);
        while (detectOut === 1'b1)
        begin
            check(indicatorOut, ~en);
            hi++;
            @(negedge clk_sys);
        end
        if (want)
            check(hi >= HOLD * DIV - 2 && hi <= HOLD * DIV, 1'b1);
        repeat (3 * DIV) @(negedge clk_sys);
    endtask : try_pulse

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            complete_run();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        void'($urandom(32'h1819));
        do_reset();
        run_startup();
        // Single mode, each comparator with the indicator on and off
        for (int i = 0; i < 4; i++)
        begin
            u_src.set_straps(1'b0, i[1]);
            try_pulse(i[0], 4, 1'b1, i[1]);
        end
        try_pulse(1'b1, 1, 1'b0, 1'b1);
        // Random lengths: one tick is a glitch, four or more is motion
        for (int i = 0; i < 6; i++)
        begin
            len = ($urandom % 2) ? 1 : 4 + $urandom % 3;
            side = $urandom % 2;
            enN = $urandom % 2;
            u_src.set_straps(1'b0, enN);
            try_pulse(side, len, len >= 4, enN);
        end
        // Dual mode: opposite pair in time, then an expired pair
        u_src.set_straps(1'b1, 1'b0);
        try_pulse(1'b1, 4, 1'b0, 1'b0);
        try_pulse(1'b0, 4, 1'b1, 1'b0);
        try_pulse(1'b0, 4, 1'b0, 1'b0);
        repeat (TOUT * DIV) @(negedge clk_sys);
        try_pulse(1'b1, 4, 1'b0, 1'b0);
        try_pulse(1'b0, 4, 1'b1, 1'b0);
        // Reset in mid-hold restarts the start-up phase
        u_src.set_straps(1'b0, 1'b0);
        fork
            u_src.pulse(1'b0, 4);
        join_none
        repeat (7 * DIV) @(negedge clk_sys);
        check(detectOut, 1'b1);
        // Enable low freezes the hold counter, so detect outlasts its hold time
        @(posedge clk_sys);
        ce <= 1'b0;
        repeat (HOLD * DIV * 2) @(negedge clk_sys);
        check(detectOut, 1'b1);
        @(posedge clk_sys);
        ce <= 1'b1;
        do_reset();
        run_startup();
        complete_run();
    end
endmodule : tb_pir_detect

`default_nettype wire
